/* File: logic/pmc_pkg.sv */
// Shared constants and types for the E1 performance monitor counters
package pmc_pkg;
    // Structure
    localparam int NUM_LINKS = 4;
    localparam int NUM_KINDS = 9;
    localparam int SNAP_W    = 16;   // Widest counter, width of a snapshot

    // Timing
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SECOND_NS       = 1_000_000_000;
    localparam int SECOND_CYCLES   = SECOND_NS / CLOCK_PERIOD_NS;

    // Event kinds, bit k of an event or flag vector
    localparam int K_LINE   = 0;
    localparam int K_FRAME  = 1;
    localparam int K_CSUM   = 2;
    localparam int K_RBLK   = 3;
    localparam int K_ALIGN  = 4;
    localparam int K_SYNC   = 5;
    localparam int K_PATT   = 6;
    localparam int K_NTRBLK = 7;
    localparam int K_NTCSUM = 8;

    // Counter widths, indexed by kind
    localparam int CNT_WIDTH [NUM_KINDS] =
        '{16, 12, 10, 10, 3, 5, 16, 10, 10};
    // Indirect index of the low byte, indexed by kind
    localparam logic [3:0] IDX_LOW [NUM_KINDS] =
        '{4'h8, 4'h2, 4'h0, 4'hC, 4'h4, 4'h5, 4'h6, 4'hE, 4'hA};
    // Kinds that occupy two indirect bytes
    localparam logic [NUM_KINDS-1:0] WIDE_MASK = 9'h1CF;

    // Bus addressing: byte address is four times the register index
    localparam int ADDR_W   = 12;
    localparam int WORD_LSB = 2;
    localparam int LINK_LSB = 10;
    localparam logic [7:0] IDX_SELECT   = 8'h0E;
    localparam logic [7:0] IDX_DATA     = 8'h0F;
    localparam logic [7:0] IDX_CONTROL  = 8'hC2;
    localparam logic [7:0] IDX_ENABLE0  = 8'hC3;
    localparam logic [7:0] IDX_ENABLE1  = 8'hC4;
    localparam logic [7:0] IDX_FLAGS0   = 8'hC5;
    localparam logic [7:0] IDX_FLAGS1   = 8'hC6;

    // Field layout
    localparam int SEL_INDEX_LSB = 0;   // Indirect index, 4 bits
    localparam int SEL_CHAN_LSB  = 4;   // Channel select, 2 bits
    localparam int CTL_TRIG_BIT  = 0;   // Manual snapshot trigger
    localparam int CTL_AUTO_BIT  = 1;   // Periodic refresh enable
    localparam int FL0_LSB = 2;         // Flags/enables 0 hold kinds 2..8
    localparam int FL0_W   = 7;
    localparam int FL1_LSB = 0;         // Flags/enables 1 hold kinds 0..1
    localparam int FL1_W   = 2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded register
    typedef enum {RG_NONE, RG_SELECT, RG_DATA, RG_CONTROL, RG_ENABLE0,
                  RG_ENABLE1, RG_FLAGS0, RG_FLAGS1} pmc_reg_e;

    // Per-link event strobes from the receive path, line code is bit 0
    typedef struct packed {
        logic ntCsum;
        logic ntRblk;
        logic patt;
        logic syncLoss;
        logic align;
        logic rblk;
        logic csum;
        logic frame;
        logic lineViol;
    } pmc_events_s;
endpackage

/* File: logic/pmc_event_counter.sv */
// One event counter with snapshot capture and overflow pulse
`timescale 1ns/1ps
module pmc_event_counter #(
    parameter int WIDTH = 16
) (
    // Clock and synchronised reset
    input  logic                      clock,
    input  logic                      rstN,
    // Event and snapshot strobes
    input  logic                      countEvent,
    input  logic                      takeSnap,
    // Captured value and overflow pulse
    output logic [pmc_pkg::SNAP_W-1:0] snapValue,
    output logic                      overflow
);
    logic [WIDTH-1:0] count_r;      // Running count of this period
    logic [WIDTH-1:0] capt_r;       // Value of the last closed period
    logic             ovf_r;        // One-cycle overflow pulse

    // Running count; restarts on a snapshot [R5]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            count_r <= '0;
        else if (takeSnap)
            count_r <= '0;                              // [R5]
        else if (countEvent)
            count_r <= WIDTH'(count_r + 1'b1);          // Wraps on overflow
    end

    // Capture; an event in the snapshot cycle lands here, not lost [R6]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            capt_r <= '0;
        else if (takeSnap)
            capt_r <= WIDTH'(count_r + WIDTH'(countEvent)); // [R6]
    end

    // Overflow when an event meets a full count [R1]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            ovf_r <= 1'b0;
        else
            ovf_r <= countEvent && (&count_r);          // [R1]
    end

    assign snapValue = pmc_pkg::SNAP_W'(capt_r);
    assign overflow  = ovf_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    a_snap_restart: assert property ( // [R5]
        takeSnap |=> count_r == '0)
        else $error("count not restarted after snapshot");

    a_snap_keeps_event: assert property ( // [R6]
        takeSnap |=> capt_r ==
            WIDTH'($past(count_r) + WIDTH'($past(countEvent))))
        else $error("snapshot lost the count or a coincident event");

    a_wrap_flags: assert property ( // [R1]
        (countEvent && (&count_r)) |=> overflow && count_r == '0)
        else $error("full counter did not wrap with overflow");
endmodule // pmc_event_counter

/* File: logic/pmc_monitor.sv */
// E1 performance monitor: counters, snapshots, flags and AXI4-Lite regs
//
// Notes on behaviour
// R1: One counter per event; overflow sets flag
// R2: Interrupt only when the paired enable set
// R3: Periodic enable copies counters every second
// R4: Trigger rising edge copies counters, always
// R5: Counters clear after each copy
// R6: Events during a copy are never lost
// R7: Two-bit channel select picks the link
// R8: Four-bit index picks one of sixteen
// R9: Selected byte shown in eight-bit data
// R10: Line violations, 16 bits, indices 9/8
// R11: Framing errors, 12 bits, indices 3/2
// R12: Checksum errors, 10 bits, indices 1/0
// R13: Remote block errors, 10 bits, D/C
// R14: Alignment shifts, 3 bits, index 4
// R15: Sync losses, 5 bits, index 5
// R16: Pattern errors, 16 bits, indices 7/6
// R17: NT remote block errors, 10 bits, F/E
// R18: NT checksum errors, 10 bits, B/A
// R19: Low byte at lower index
// R20: Flags stay set until written one
`timescale 1ns/1ps
module pmc_monitor #(
    parameter int SECOND_CYCLES = pmc_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input  logic                          clock,
    input  logic                          nrst,
    // AXI4-Lite write address
    input  logic                          awvalid,
    output logic                          awready,
    input  logic [pmc_pkg::ADDR_W-1:0]    awaddr,
    // AXI4-Lite write data
    input  logic                          wvalid,
    output logic                          wready,
    input  logic [31:0]                   wdata,
    input  logic [3:0]                    wstrb,
    // AXI4-Lite write response
    output logic                          bvalid,
    input  logic                          bready,
    output logic [1:0]                    bresp,
    // AXI4-Lite read address
    input  logic                          arvalid,
    output logic                          arready,
    input  logic [pmc_pkg::ADDR_W-1:0]    araddr,
    // AXI4-Lite read data
    output logic                          rvalid,
    input  logic                          rready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    // Event strobes from the receive path, one struct per link
    input  pmc_pkg::pmc_events_s          linkEvents [pmc_pkg::NUM_LINKS],
    // Overflow interrupt, active high
    output logic                          perfIrq
);
    localparam int NL  = pmc_pkg::NUM_LINKS;
    localparam int NK  = pmc_pkg::NUM_KINDS;
    localparam int SW  = pmc_pkg::SNAP_W;
    localparam int SEC_W = $clog2(SECOND_CYCLES);

    // Reset synchroniser
    logic [1:0] rstPipe_r;
    logic       rstN;                         // Synchronised reset copy

    // Bus state
    logic                       awready_r, wready_r, bvalid_r;
    logic                       arready_r, rvalid_r;
    logic [1:0]                 bresp_r, rresp_r;
    logic [31:0]                rdata_r;
    logic                       awHeld_r, wHeld_r;   // Halves of a write
    logic [pmc_pkg::ADDR_W-1:0] awAddr_r;
    logic [31:0]                wData_r;
    logic [3:0]                 wStrb_r;
    logic                       doWrite;             // Both halves present
    pmc_pkg::pmc_reg_e          wReg, rReg;
    logic [1:0]                 wLink, rLink;
    logic                       wLane0;              // Low byte written

    // Software registers
    logic [7:0]          select_r;                   // Channel and index
    logic [1:0]          ctrl_r    [NL];             // Trigger, periodic
    logic [NK-1:0]       enable_r  [NL];             // Overflow enables
    logic [NK-1:0]       flags_r   [NL];             // Overflow flags
    logic [NL-1:0]       trigPrev_r;                 // Trigger last cycle
    logic [NL-1:0]       snap_r;                     // Snapshot pulse
    logic [7:0]          indirectData_r;             // Selected byte
    logic                perfIrq_r;

    // Second timer
    logic [SEC_W-1:0]    secCount_r;
    logic                secTick_r;

    // Counter array outputs
    logic [NK-1:0][SW-1:0] snapVal [NL];
    logic [NK-1:0]         ovf     [NL];
    logic [NK-1:0]         clrVec  [NL];
    logic [NL-1:0]         maskedAny;
    logic [31:0]           readValue;
    logic [1:0]            readResp;

    // Register decode, used by both bus directions
    function automatic pmc_pkg::pmc_reg_e decodeReg(
        input logic [pmc_pkg::ADDR_W-1:0] a);
        logic [7:0] low;
        logic [1:0] lk;
        low = a[pmc_pkg::WORD_LSB +: 8];
        lk  = a[pmc_pkg::LINK_LSB +: 2];
        decodeReg = pmc_pkg::RG_NONE;
        if (a[pmc_pkg::WORD_LSB-1:0] == '0)
        begin
            case (low)
                // Access port and data exist once, in link 0 space
                pmc_pkg::IDX_SELECT:
                    if (lk == 2'h0) decodeReg = pmc_pkg::RG_SELECT;
                pmc_pkg::IDX_DATA:
                    if (lk == 2'h0) decodeReg = pmc_pkg::RG_DATA;
                pmc_pkg::IDX_CONTROL: decodeReg = pmc_pkg::RG_CONTROL;
                pmc_pkg::IDX_ENABLE0: decodeReg = pmc_pkg::RG_ENABLE0;
                pmc_pkg::IDX_ENABLE1: decodeReg = pmc_pkg::RG_ENABLE1;
                pmc_pkg::IDX_FLAGS0:  decodeReg = pmc_pkg::RG_FLAGS0;
                pmc_pkg::IDX_FLAGS1:  decodeReg = pmc_pkg::RG_FLAGS1;
                default:              decodeReg = pmc_pkg::RG_NONE;
            endcase
        end
    endfunction

    // Byte of a link's snapshots at an indirect index
    function automatic logic [7:0] indirectByte(
        input logic [NK-1:0][SW-1:0] v, input logic [3:0] idx);
        indirectByte = 8'h00;
        for (int k = 0; k < NK; k++)
        begin
            if (idx == pmc_pkg::IDX_LOW[k])
                indirectByte = v[k][7:0];                  // [R19]
            else if (pmc_pkg::WIDE_MASK[k] &&
                     idx == 4'(pmc_pkg::IDX_LOW[k] + 4'h1))
                indirectByte = v[k][15:8];                 // [R19]
        end
    endfunction

    // Reset release through two flops
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rstPipe_r <= 2'h0;
        else
            rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
    assign rstN = rstPipe_r[1];

    assign wReg    = decodeReg(awAddr_r);
    assign wLink   = awAddr_r[pmc_pkg::LINK_LSB +: 2];
    assign rReg    = decodeReg(araddr);
    assign rLink   = araddr[pmc_pkg::LINK_LSB +: 2];
    assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
    assign wLane0  = doWrite && wStrb_r[0];

    // Write address channel, taken independently of data
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            awready_r <= 1'b0;
            awHeld_r  <= 1'b0;
            awAddr_r  <= '0;
        end
        else if (awvalid && awready_r)
        begin
            awready_r <= 1'b0;
            awHeld_r  <= 1'b1;
            awAddr_r  <= awaddr;
        end
        else if (doWrite)
            awHeld_r  <= 1'b0;
        else if (!awHeld_r && !bvalid_r)
            awready_r <= 1'b1;
    end

    // Write data channel
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            wready_r <= 1'b0;
            wHeld_r  <= 1'b0;
            wData_r  <= '0;
            wStrb_r  <= '0;
        end
        else if (wvalid && wready_r)
        begin
            wready_r <= 1'b0;
            wHeld_r  <= 1'b1;
            wData_r  <= wdata;
            wStrb_r  <= wstrb;
        end
        else if (doWrite)
            wHeld_r  <= 1'b0;
        else if (!wHeld_r && !bvalid_r)
            wready_r <= 1'b1;
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= pmc_pkg::RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wReg == pmc_pkg::RG_NONE) ?
                        pmc_pkg::RESP_SLVERR : pmc_pkg::RESP_OKAY;
        end
        else if (bready)
            bvalid_r <= 1'b0;
    end

    // Channel and index selector, shared by all links [R7] [R8]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            select_r <= 8'h00;
        else if (wLane0 && wReg == pmc_pkg::RG_SELECT)
            select_r <= wData_r[7:0];
    end

    // Per-link control, enables and sticky flags
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            for (int l = 0; l < NL; l++)
            begin
                ctrl_r[l]   <= 2'h0;
                enable_r[l] <= '0;
                flags_r[l]  <= '0;
            end
        end
        else
        begin
            for (int l = 0; l < NL; l++)
            begin
                if (wLane0 && wLink == 2'(l))
                begin
                    if (wReg == pmc_pkg::RG_CONTROL)
                        ctrl_r[l] <= wData_r[1:0];
                    if (wReg == pmc_pkg::RG_ENABLE0)
                        enable_r[l][pmc_pkg::FL0_LSB +: pmc_pkg::FL0_W]
                            <= wData_r[pmc_pkg::FL0_W-1:0];
                    if (wReg == pmc_pkg::RG_ENABLE1)
                        enable_r[l][pmc_pkg::FL1_LSB +: pmc_pkg::FL1_W]
                            <= wData_r[pmc_pkg::FL1_W-1:0];
                end
                // Set wins over a clear in the same cycle [R1] [R20]
                flags_r[l] <= ovf[l] | (flags_r[l] & ~clrVec[l]);
            end
        end
    end

    // Write-one-to-clear masks per link [R20]
    always_comb
    begin
        for (int l = 0; l < NL; l++)
        begin
            clrVec[l] = '0;
            if (wLane0 && wLink == 2'(l))
            begin
                if (wReg == pmc_pkg::RG_FLAGS0)
                    clrVec[l][pmc_pkg::FL0_LSB +: pmc_pkg::FL0_W] =
                        wData_r[pmc_pkg::FL0_W-1:0];
                if (wReg == pmc_pkg::RG_FLAGS1)
                    clrVec[l][pmc_pkg::FL1_LSB +: pmc_pkg::FL1_W] =
                        wData_r[pmc_pkg::FL1_W-1:0];
            end
        end
    end

    // One-second tick shared by all links
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            secCount_r <= '0;
            secTick_r  <= 1'b0;
        end
        else if (secCount_r == SEC_W'(SECOND_CYCLES - 1))
        begin
            secCount_r <= '0;
            secTick_r  <= 1'b1;
        end
        else
        begin
            secCount_r <= SEC_W'(secCount_r + 1'b1);
            secTick_r  <= 1'b0;
        end
    end

    // Snapshot pulses: periodic or trigger rising edge [R3] [R4]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            trigPrev_r <= '0;
            snap_r     <= '0;
        end
        else
        begin
            for (int l = 0; l < NL; l++)
            begin
                trigPrev_r[l] <= ctrl_r[l][pmc_pkg::CTL_TRIG_BIT];
                snap_r[l] <=
                    (secTick_r && ctrl_r[l][pmc_pkg::CTL_AUTO_BIT]) || // [R3]
                    (ctrl_r[l][pmc_pkg::CTL_TRIG_BIT] &&
                     !trigPrev_r[l]);                                  // [R4]
            end
        end
    end

    // Counter array, one per link and event kind
    for (genvar l = 0; l < NL; l++)
    begin : g_link
        logic [NK-1:0] evVec;
        assign evVec = linkEvents[l];
        for (genvar k = 0; k < NK; k++) // [R10] [R11] [R12] [R13] [R14]
        begin : g_kind
            pmc_event_counter #(
                .WIDTH      (pmc_pkg::CNT_WIDTH[k]) // [R15] [R16] [R17] [R18]
            ) u_counter (
                .clock      (clock),
                .rstN       (rstN),
                .countEvent (evVec[k]),                 // [R1]
                .takeSnap   (snap_r[l]),                // [R5]
                .snapValue  (snapVal[l][k]),
                .overflow   (ovf[l][k])
            );
        end
        assign maskedAny[l] = |(flags_r[l] & enable_r[l]);
    end

    // Indirect read byte, refreshed every cycle [R7] [R8] [R9]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            indirectData_r <= 8'h00;
        else
            indirectData_r <= indirectByte(
                snapVal[select_r[pmc_pkg::SEL_CHAN_LSB +: 2]],
                select_r[pmc_pkg::SEL_INDEX_LSB +: 4]);
    end

    // Interrupt only through enabled flags [R2]
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            perfIrq_r <= 1'b0;
        else
            perfIrq_r <= |maskedAny;                    // [R2]
    end

    // Read value mux; reserved bits read zero
    always_comb
    begin
        readValue = 32'h0000_0000;
        readResp  = pmc_pkg::RESP_OKAY;
        case (rReg)
            pmc_pkg::RG_SELECT:  readValue[7:0] = select_r;
            pmc_pkg::RG_DATA:    readValue[7:0] = indirectData_r; // [R9]
            pmc_pkg::RG_CONTROL: readValue[1:0] = ctrl_r[rLink];
            pmc_pkg::RG_ENABLE0: readValue[pmc_pkg::FL0_W-1:0] =
                enable_r[rLink][pmc_pkg::FL0_LSB +: pmc_pkg::FL0_W];
            pmc_pkg::RG_ENABLE1: readValue[pmc_pkg::FL1_W-1:0] =
                enable_r[rLink][pmc_pkg::FL1_LSB +: pmc_pkg::FL1_W];
            pmc_pkg::RG_FLAGS0:  readValue[pmc_pkg::FL0_W-1:0] =
                flags_r[rLink][pmc_pkg::FL0_LSB +: pmc_pkg::FL0_W];
            pmc_pkg::RG_FLAGS1:  readValue[pmc_pkg::FL1_W-1:0] =
                flags_r[rLink][pmc_pkg::FL1_LSB +: pmc_pkg::FL1_W];
            default:             readResp = pmc_pkg::RESP_SLVERR;
        endcase
    end

    // Read channel: one read in flight, answer the next cycle
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= pmc_pkg::RESP_OKAY;
        end
        else if (arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= readValue;
            rresp_r   <= readResp;
        end
        else if (rvalid_r && rready)
            rvalid_r  <= 1'b0;
        else if (!rvalid_r)
            arready_r <= 1'b1;
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign perfIrq = perfIrq_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    sequence sDataRead;
        arvalid && arready_r && decodeReg(araddr) == pmc_pkg::RG_DATA;
    endsequence

    a_read_data: assert property ( // [R9]
        sDataRead |=> rvalid_r && rdata_r[7:0] == $past(indirectData_r))
        else $error("indirect data read returned wrong byte");

    a_read_hold: assert property (
        rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
        else $error("read answer changed before taken");

    a_irq_quiet: assert property ( // [R2]
        maskedAny == '0 |=> !perfIrq_r)
        else $error("interrupt without an enabled flag");

    for (genvar l = 0; l < NL; l++)
    begin : g_check
        sequence sTrigWrite;
            wLane0 && wReg == pmc_pkg::RG_CONTROL && wLink == 2'(l) &&
            wData_r[pmc_pkg::CTL_TRIG_BIT] &&
            !ctrl_r[l][pmc_pkg::CTL_TRIG_BIT];
        endsequence
        sequence sEnabledOverflow;
            (ovf[l] & enable_r[l]) != '0 ##1
            (flags_r[l] & enable_r[l]) != '0;
        endsequence

        a_manual_snap: assert property ( // [R4]
            sTrigWrite |-> ##2 snap_r[l])
            else $error("trigger rise did not snapshot");

        a_auto_snap: assert property ( // [R3]
            secTick_r && ctrl_r[l][pmc_pkg::CTL_AUTO_BIT] |=> snap_r[l])
            else $error("periodic snapshot missed");

        a_flag_sticky: assert property ( // [R20]
            clrVec[l] == '0 |=>
                (flags_r[l] & $past(flags_r[l])) == $past(flags_r[l]))
            else $error("overflow flag dropped without a clear");

        a_irq_raise: assert property ( // [R2]
            sEnabledOverflow |=> perfIrq_r)
            else $error("enabled overflow raised no interrupt");
    end
endmodule // pmc_monitor

/* File: sim/pmc_event_source.sv */
// Event source standing in for the receive framer and checker
`timescale 1ns/1ps
module pmc_event_source (
    // Request from the bench
    input  wire logic            clock,
    input  wire logic            go,
    input  wire logic [1:0]      link,
    input  wire logic [3:0]      kind,
    input  wire logic [15:0]     num,
    // One-cycle strobes, quiet when idle
    output pmc_pkg::pmc_events_s linkEvents [pmc_pkg::NUM_LINKS]
);
    logic [15:0] left_r = 16'h0;
    logic [1:0]  link_r = 2'h0;
    logic [3:0]  kind_r = 4'h0;
    // Latch a request, then one event per cycle
    always_ff @(posedge clock)
        if (go) {left_r, link_r, kind_r} <= {num, link, kind};
        else if (left_r != 16'h0) left_r <= left_r - 16'h1;
    always_comb
        for (int i = 0; i < pmc_pkg::NUM_LINKS; i++)
            linkEvents[i] = (left_r != 16'h0 && link_r == 2'(i)) ?
                pmc_pkg::pmc_events_s'(9'h001 << kind_r) : '0;
endmodule // pmc_event_source

/* File: sim/tb_top.sv */
// Self-checking bench for the performance monitor
`timescale 1ns/1ps
module tb_top;
    logic        clock = 1'b0, nrst = 1'b0, go = 1'b0, perfIrq;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rdD;
    logic [1:0]  bresp, rresp, br, rr, gLink = 2'h0;
    logic [3:0]  gKind = 4'h0;
    logic [15:0] gNum = 16'h0;
    int          errTotal = 0, checkCount = 0;
    pmc_pkg::pmc_events_s linkEvents [pmc_pkg::NUM_LINKS];
    always #5 clock = ~clock;
    // Short second so periodic copies come quickly
    pmc_monitor #(.SECOND_CYCLES(50)) DUT (.clock(clock), .nrst(nrst),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .linkEvents(linkEvents), .perfIrq(perfIrq));
    pmc_event_source FAR (.clock(clock), .go(go), .link(gLink),
        .kind(gKind), .num(gNum), .linkEvents(linkEvents));
    task automatic chk(input string n, input logic [31:0] s, e);
        checkCount++;
        if (s !== e)
        begin
            errTotal++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [11:0] ad(input logic [1:0] l, input int i);
        return {l, 8'(i), 2'h0};
    endfunction
    // Bus write; each valid drops once its ready was seen
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        {awaddr, wdata} <= {a, 24'h0, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        br = bresp;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        {rdD, rr} = {rdata, rresp};
    endtask
    task automatic ev(input int l, k, n);
        @(posedge clock);
        {go, gLink, gKind, gNum} <= {1'b1, 2'(l), 4'(k), 16'(n)};
        @(posedge clock);
        go <= 1'b0;
        repeat (n + 3) @(posedge clock);
    endtask
    // Select, settle two cycles, then fetch the byte
    task automatic rdi(input int l, i, e);
        wr(ad(2'h0, pmc_pkg::IDX_SELECT), {2'h0, 2'(l), 4'(i)});
        repeat (2) @(posedge clock);
        rd(ad(2'h0, pmc_pkg::IDX_DATA));
        chk("indirect", rdD, 32'(e));
    endtask
    task automatic snap(input int l);
        wr(ad(2'(l), pmc_pkg::IDX_CONTROL), 8'h00);
        wr(ad(2'(l), pmc_pkg::IDX_CONTROL), 8'h01);
        repeat (4) @(posedge clock);
    endtask
    function automatic int cnt(input int k);
        return (k == 0) ? 300 : k + 1;
    endfunction
    task automatic t_count;
        for (int k = 0; k < pmc_pkg::NUM_KINDS; k++)
            ev(1, k, cnt(k));
        snap(1);
        for (int k = 0; k < pmc_pkg::NUM_KINDS; k++)
        begin
            rdi(1, pmc_pkg::IDX_LOW[k], cnt(k) % 256);
            if (pmc_pkg::WIDE_MASK[k])
                rdi(1, pmc_pkg::IDX_LOW[k] + 1, cnt(k) / 256);
        end
        snap(1);
        rdi(1, pmc_pkg::IDX_LOW[0], 0);
    endtask
    // Alignment counter wraps after eight events
    task automatic t_ovf;
        ev(2, pmc_pkg::K_ALIGN, 8);
        rd(ad(2'h2, pmc_pkg::IDX_FLAGS0));
        chk("flag", rdD, 32'h4);
        chk("irq off", perfIrq, 32'h0);
        wr(ad(2'h2, pmc_pkg::IDX_ENABLE0), 8'h04);
        repeat (3) @(posedge clock);
        chk("irq on", perfIrq, 32'h1);
        wr(ad(2'h2, pmc_pkg::IDX_FLAGS0), 8'h04);
        repeat (3) @(posedge clock);
        rd(ad(2'h2, pmc_pkg::IDX_FLAGS0));
        chk("flag clr", rdD, 32'h0);
        chk("irq clr", perfIrq, 32'h0);
        ev(2, pmc_pkg::K_ALIGN, 8);
        chk("irq again", perfIrq, 32'h1);
        wr(ad(2'h2, pmc_pkg::IDX_FLAGS0), 8'h04);
    endtask
    // Framing counter wraps after 4096 events; flag in second register
    task automatic t_wide;
        ev(0, pmc_pkg::K_FRAME, 4096);
        rd(ad(2'h0, pmc_pkg::IDX_FLAGS1));
        chk("flag1", rdD, 32'h2);
        wr(ad(2'h0, pmc_pkg::IDX_ENABLE1), 8'h02);
        repeat (3) @(posedge clock);
        chk("irq1", perfIrq, 32'h1);
    endtask
    // Copy phase unknown, so poll until it lands
    task automatic t_per;
        wr(ad(2'h3, pmc_pkg::IDX_CONTROL), 8'h02);
        ev(3, pmc_pkg::K_FRAME, 1);
        wr(ad(2'h0, pmc_pkg::IDX_SELECT), 8'h32);
        rdD = 32'h0;
        for (int i = 0; i < 40 && rdD === 32'h0; i++)
            rd(ad(2'h0, pmc_pkg::IDX_DATA));
        chk("periodic", rdD, 32'h1);
        rd(12'h000);
        chk("bad rd", {rdD[29:0], rr}, 32'h2);
        wr(12'h004, 8'h01);
        chk("bad wr", br, 32'h2);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        errTotal++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_count();
        t_ovf();
        t_wide();
        t_per();
        conclude();
    end
endmodule // tb_top
